// ---- hw/cbsl_pkg.sv ----
// Purpose: Shared constants and carriers for the control bus status logic
// Assumes: 100 MHz core clock
// Notes: Abort gap and conversion times are kept in ns, their cycle counts derive from them
package cbsl_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int FAST_ABORT_GAP_NS = 600;
  localparam int FAST_ABORT_GAP_CYC =
    (FAST_ABORT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_TIME_NS = 5700;
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ANALOG_RST_CYC = 4;
  localparam int CFG_LAMP_CYC = 1000;
  localparam int CNT_W = 16;
  localparam int WIN_W = 8;
  localparam int ADDR_W = 16;
  localparam int STAT_DATA = 0;
  localparam int STAT_DATA_LINE = 1;
  localparam int STAT_BUSY = 2;
  localparam int STAT_BUSY_LINE = 3;
  localparam int STAT_W = 4;
  localparam logic [STAT_W-1:0] STAT_RST = 4'h0;

  typedef enum logic [1:0] {
    CBSL_IDLE = 2'b00,
    CBSL_GATE = 2'b01,
    CBSL_CONV = 2'b10,
    CBSL_CLR = 2'b11
  } cbsl_state_t;

  // Front panel lamps
  typedef struct packed {
    logic bus_ack_green;
    logic busy_red;
    logic data_yellow;
    logic term_green;
    logic term_red;
    logic term_orange;
  } cbsl_lamp_t;

  // Wired line drive: output and output enable
  typedef struct packed {
    logic pos_o;
    logic pos_oe;
    logic neg_o;
    logic neg_oe;
  } cbsl_wire_t;
endpackage

// ---- hw/cbsl_top.sv ----
// Purpose: Front panel control bus and status logic of a charge converter
// Assumes: Control bus inputs are asynchronous, core clock 100 MHz
// Notes: Analog sections are reached through pulse and level ports
// Functional notes
// - Fast abort honoured only inside its window
// - Window from gate edge; 600 ns regate
// - Panel reset clears integrators, buffer, conversion
// - Reset type select decides register clearing
// - Select 0 data reset, 1 software reset
// - Data present output and status bit 0
// - Wired OR/NAND data lines, sense bit 1
// - Common gate window enables channel gates
// - Veto inhibits conversion
// - Busy on convert, reset, test, full; bit 2
// - Wired OR/NAND busy lines, sense bit 3
// - Busy after gate edge, gates ignored
// - Panel gate ORed with bus gate
// - Green lamp on bus access to own address
// - Red lamp follows busy conditions
// - Yellow lamp when buffer holds events
// - Configuration lights busy, data, orange
// - Termination lamp green, red or off
// - Busy scope jumper chain or local
// - Rotary selectors set decoded base address
`timescale 1ns/1ns
module cbsl_top
  import cbsl_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC,
  parameter int CFG_CYCLES = CFG_LAMP_CYC,
  parameter int TERM_LINES = 14
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Asynchronous control bus inputs
  input wire logic GATE_BUS,
  input wire logic GATE_PANEL,
  input wire logic FAST_ABORT_IN,
  input wire logic VETO,
  input wire logic PANEL_RESET,
  // Configuration and board state
  input wire logic RESET_TYPE_SELECT,
  input wire logic [cbsl_pkg::WIN_W-1:0] FAST_ABORT_WINDOW,
  input wire logic BUSY_SCOPE_JUMPER,
  input wire logic [3:0][3:0] ROTARY_SEL,
  input wire logic [TERM_LINES-1:0] TERM_ON,
  input wire logic MEM_TEST,
  input wire logic EVENT_BUFFER_FULL,
  input wire logic EVENT_BUFFER_NONEMPTY,
  input wire logic CONFIGURING,
  // Host bus access sense
  input wire logic HOST_STROBE,
  input wire logic [cbsl_pkg::ADDR_W-1:0] HOST_ADDR,
  // Wired lines: sensed levels and drive
  input wire logic DATA_PRESENT_OR_LINE_I,
  input wire logic BUSY_OR_LINE_I,
  output cbsl_pkg::cbsl_wire_t DATA_PRESENT_LINE,
  output cbsl_pkg::cbsl_wire_t BUSY_LINE,
  // Analog and buffer control
  output logic GATE_WINDOW,
  output logic CONVERT_START,
  output logic INTEGRATOR_CLEAR,
  output logic CONVERT_ABORT,
  output logic BUFFER_RESET,
  output logic REG_DEFAULTS,
  output logic ACQ_STOP,
  output logic HOST_SELECT,
  // Status and lamps
  output logic [cbsl_pkg::STAT_W-1:0] STATUS,
  output cbsl_pkg::cbsl_lamp_t LAMPS
);
  import cbsl_pkg::*;

  function automatic logic rise(input logic now, input logic last);
    return now & ~last;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers: first stage read only by the second
  logic [4:0] s1_r, s2_r, s3_r;
  logic [4:0] raw;
  assign raw = {PANEL_RESET, VETO, FAST_ABORT_IN, GATE_PANEL, GATE_BUS};
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1_r <= 5'h00;
      s2_r <= 5'h00;
      s3_r <= 5'h00;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  logic gate_any, gate_last, abort_edge, veto_s, rst_edge;
  assign gate_any = s2_r[0] | s2_r[1];
  assign gate_last = s3_r[0] | s3_r[1];
  assign abort_edge = rise(s2_r[2], s3_r[2]);
  assign veto_s = s2_r[3];
  assign rst_edge = rise(s2_r[4], s3_r[4]);

  ////////////////////////////////////////////////////////////////////////
  // Acquisition sequencer
  cbsl_state_t st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [WIN_W-1:0] win_r, win_nxt;
  logic [CNT_W-1:0] gap_r, gap_nxt;
  logic vetoed_r, vetoed_nxt;
  logic start_nxt, clr_nxt, abort_nxt, bufrst_nxt, regdef_nxt;
  logic start_r, clr_r, abort_r, bufrst_r, regdef_r;
  logic busy_local, busy_sel;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    win_nxt = win_r;
    vetoed_nxt = vetoed_r;
    gap_nxt = (gap_r != '0) ? gap_r - 1'b1 : gap_r;
    start_nxt = 1'b0;
    clr_nxt = 1'b0;
    abort_nxt = 1'b0;
    bufrst_nxt = 1'b0;
    regdef_nxt = 1'b0;
    if (win_r != '0)
      win_nxt = win_r - 1'b1;
    if (rst_edge) begin
      // Panel reset outranks every other event
      clr_nxt = 1'b1;
      abort_nxt = 1'b1;
      bufrst_nxt = 1'b1;
      regdef_nxt = RESET_TYPE_SELECT;
      st_nxt = CBSL_CLR;
      cnt_nxt = CNT_W'(ANALOG_RST_CYC);
      win_nxt = '0;
    end else begin
      unique case (st_r)
        CBSL_IDLE: begin
          // Busy or recent abort masks new gates; a full buffer or a
          // memory test keeps this board busy even in local scope
          if (rise(gate_any, gate_last) && gap_r == '0 &&
              !busy_sel) begin
            st_nxt = CBSL_GATE;
            win_nxt = FAST_ABORT_WINDOW;
            vetoed_nxt = veto_s;
          end
        end
        CBSL_GATE: begin
          vetoed_nxt = vetoed_r | veto_s;
          if (abort_edge && win_r != '0) begin
            clr_nxt = 1'b1;
            abort_nxt = 1'b1;
            gap_nxt = CNT_W'(FAST_ABORT_GAP_CYC - 1);
            st_nxt = CBSL_IDLE;
            win_nxt = '0;
          end else if (!gate_any) begin
            if (vetoed_r | veto_s) begin
              clr_nxt = 1'b1;
              st_nxt = CBSL_CLR;
              cnt_nxt = CNT_W'(ANALOG_RST_CYC);
            end else begin
              start_nxt = 1'b1;
              st_nxt = CBSL_CONV;
              cnt_nxt = CNT_W'(CONV_CYCLES);
            end
          end
        end
        CBSL_CONV: begin
          if (abort_edge && win_r != '0) begin
            clr_nxt = 1'b1;
            abort_nxt = 1'b1;
            gap_nxt = CNT_W'(FAST_ABORT_GAP_CYC - 1);
            st_nxt = CBSL_IDLE;
          end else if (cnt_r <= CNT_W'(1)) begin
            st_nxt = CBSL_IDLE;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        CBSL_CLR: begin
          if (cnt_r <= CNT_W'(1))
            st_nxt = CBSL_IDLE;
          else
            cnt_nxt = cnt_r - 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_r <= CBSL_IDLE;
      cnt_r <= '0;
      win_r <= '0;
      gap_r <= '0;
      vetoed_r <= 1'b0;
      start_r <= 1'b0;
      clr_r <= 1'b0;
      abort_r <= 1'b0;
      bufrst_r <= 1'b0;
      regdef_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      win_r <= win_nxt;
      gap_r <= gap_nxt;
      vetoed_r <= vetoed_nxt;
      start_r <= start_nxt;
      clr_r <= clr_nxt;
      abort_r <= abort_nxt;
      bufrst_r <= bufrst_nxt;
      regdef_r <= regdef_nxt;
    end
  end

  assign busy_local = (st_r != CBSL_IDLE) | MEM_TEST |
                      EVENT_BUFFER_FULL;
  // Chain scope looks at the sensed wired OR, local scope at this board
  assign busy_sel = BUSY_SCOPE_JUMPER ? BUSY_OR_LINE_I : busy_local;

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs, lamps and host select
  logic [STAT_W-1:0] stat_r, stat_nxt;
  cbsl_lamp_t lamp_r, lamp_nxt;
  localparam int TC_W = $clog2(TERM_LINES + 1);
  logic win_out_r, win_out_nxt, stop_r, stop_nxt, sel_r, sel_nxt;
  logic [TC_W-1:0] term_cnt;

  always_comb begin
    term_cnt = '0;
    for (int i = 0; i < TERM_LINES; i++)
      term_cnt = term_cnt + TC_W'(TERM_ON[i]);
    stat_nxt = STAT_RST;
    // Window closes once conversion starts, so late channel gates are lost
    win_out_nxt = gate_any & (st_r != CBSL_CONV);
    stop_nxt = busy_sel;
    stat_nxt[STAT_DATA] = EVENT_BUFFER_NONEMPTY;
    stat_nxt[STAT_DATA_LINE] = DATA_PRESENT_OR_LINE_I;
    stat_nxt[STAT_BUSY] = busy_local;
    stat_nxt[STAT_BUSY_LINE] = BUSY_OR_LINE_I;
    sel_nxt = HOST_STROBE &&
              HOST_ADDR == {ROTARY_SEL[3], ROTARY_SEL[2],
                            ROTARY_SEL[1], ROTARY_SEL[0]};
    lamp_nxt.bus_ack_green = sel_nxt;
    lamp_nxt.busy_red = busy_local | CONFIGURING;
    lamp_nxt.data_yellow = EVENT_BUFFER_NONEMPTY | CONFIGURING;
    lamp_nxt.term_orange = CONFIGURING;
    lamp_nxt.term_green = !CONFIGURING &&
                          term_cnt == TERM_LINES;
    lamp_nxt.term_red = !CONFIGURING && term_cnt == '0;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stat_r <= STAT_RST;
      lamp_r <= '0;
      win_out_r <= 1'b0;
      stop_r <= 1'b0;
      sel_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      lamp_r <= lamp_nxt;
      win_out_r <= win_out_nxt;
      stop_r <= stop_nxt;
      sel_r <= sel_nxt;
    end
  end

  // Open-collector style: drive OR line high and NAND line low when set
  assign DATA_PRESENT_LINE = '{pos_o: 1'b1, pos_oe: stat_r[STAT_DATA],
    neg_o: 1'b0, neg_oe: stat_r[STAT_DATA]};
  assign BUSY_LINE = '{pos_o: 1'b1, pos_oe: stat_r[STAT_BUSY],
    neg_o: 1'b0, neg_oe: stat_r[STAT_BUSY]};
  assign GATE_WINDOW = win_out_r;
  assign CONVERT_START = start_r;
  assign INTEGRATOR_CLEAR = clr_r;
  assign CONVERT_ABORT = abort_r;
  assign BUFFER_RESET = bufrst_r;
  assign REG_DEFAULTS = regdef_r;
  assign ACQ_STOP = stop_r;
  assign HOST_SELECT = sel_r;
  assign STATUS = stat_r;
  assign LAMPS = lamp_r;
endmodule // cbsl_top

// ---- test/cbsl_chk.sv ----
// Purpose: Port assertions for the control bus status logic
// Assumes: One clock, RST async high
// Notes: Bounds allow for the input sync stages
`timescale 1ns/1ns
module cbsl_chk
  import cbsl_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Watched inputs
  input wire logic PANEL_RESET,
  input wire logic RESET_TYPE_SELECT,
  input wire logic [3:0][3:0] ROTARY_SEL,
  input wire logic EVENT_BUFFER_FULL,
  input wire logic EVENT_BUFFER_NONEMPTY,
  input wire logic HOST_STROBE,
  input wire logic [cbsl_pkg::ADDR_W-1:0] HOST_ADDR,
  // Watched outputs
  input wire logic INTEGRATOR_CLEAR,
  input wire logic BUFFER_RESET,
  input wire logic REG_DEFAULTS,
  input wire logic HOST_SELECT,
  input wire logic [cbsl_pkg::STAT_W-1:0] STATUS,
  input wire cbsl_pkg::cbsl_lamp_t LAMPS
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);
  //////////////////////////////////////////////////////////////////////////
  chk_data_flag: assert property (
    $rose(EVENT_BUFFER_NONEMPTY) |-> ##[1:4]
    STATUS[STAT_DATA] && LAMPS.data_yellow) else $error("data flag late");
  chk_data_drop: assert property (
    !EVENT_BUFFER_NONEMPTY [*4] |-> !STATUS[STAT_DATA])
    else $error("data flag stuck");
  chk_full_busy: assert property (
    $rose(EVENT_BUFFER_FULL) |-> ##[1:4]
    STATUS[STAT_BUSY] && LAMPS.busy_red) else $error("full not busy");
  chk_host_hit: assert property (
    HOST_STROBE && HOST_ADDR == ROTARY_SEL |=> HOST_SELECT)
    else $error("address hit lost");
  chk_host_miss: assert property (
    !HOST_STROBE || HOST_ADDR != ROTARY_SEL |=> !HOST_SELECT)
    else $error("false select");
  chk_ack_lamp: assert property (
    $rose(HOST_SELECT) |-> ##[0:2] LAMPS.bus_ack_green)
    else $error("ack lamp dark");
  chk_reset_pulse: assert property (
    $rose(PANEL_RESET) |-> ##[2:5] INTEGRATOR_CLEAR && BUFFER_RESET)
    else $error("panel reset lost");
  chk_reset_kind: assert property (
    BUFFER_RESET |-> REG_DEFAULTS == RESET_TYPE_SELECT)
    else $error("reset kind wrong");
  cover property (HOST_SELECT);
  cover property (BUFFER_RESET && REG_DEFAULTS);
  cover property ($fell(STATUS[STAT_BUSY]));
endmodule // cbsl_chk

bind cbsl_top cbsl_chk u_chk (
  .CLK(CLK), .RST(RST), .PANEL_RESET(PANEL_RESET),
  .RESET_TYPE_SELECT(RESET_TYPE_SELECT), .ROTARY_SEL(ROTARY_SEL),
  .EVENT_BUFFER_FULL(EVENT_BUFFER_FULL),
  .EVENT_BUFFER_NONEMPTY(EVENT_BUFFER_NONEMPTY),
  .HOST_STROBE(HOST_STROBE), .HOST_ADDR(HOST_ADDR),
  .INTEGRATOR_CLEAR(INTEGRATOR_CLEAR), .BUFFER_RESET(BUFFER_RESET),
  .REG_DEFAULTS(REG_DEFAULTS), .HOST_SELECT(HOST_SELECT),
  .STATUS(STATUS), .LAMPS(LAMPS)
);

// ---- test/cbsl_peer.sv ----
// Purpose: Trigger logic and one far chained board
// Assumes: Wired lines have a pull-down
// Notes: Changes land at the falling edge
`timescale 1ns/1ns
module cbsl_peer
  import cbsl_pkg::*;
(
  // Clock
  input wire logic clk,
  // Line drive of the board under test
  input wire cbsl_pkg::cbsl_wire_t data_line,
  input wire cbsl_pkg::cbsl_wire_t busy_line,
  // Far board state
  input wire logic far_data,
  input wire logic far_busy,
  // Trigger and sensed lines
  output logic gate,
  output logic abort,
  output logic data_or,
  output logic busy_or
);
  // A released driver leaves only the far board on the line
  assign data_or = (data_line.pos_oe & data_line.pos_o) | far_data;
  assign busy_or = (busy_line.pos_oe & busy_line.pos_o) | far_busy;
  initial begin
    gate = 1'b0;
    abort = 1'b0;
  end
  task automatic pulse_gate(input int len);
    @(negedge clk);
    gate = 1'b1;
    repeat (len) @(negedge clk);
    gate = 1'b0;
  endtask
  // Held 40 ns, above the minimum width
  task automatic fast_abort(input int dly);
    repeat (dly) @(negedge clk);
    abort = 1'b1;
    repeat (4) @(negedge clk);
    abort = 1'b0;
    repeat (FAST_ABORT_GAP_CYC) @(negedge clk);
  endtask
endmodule // cbsl_peer

// ---- test/cbsl_top_test.sv ----
// Purpose: Self-checking bench for the control bus status logic
// Assumes: Conversion shortened to 10 cycles
// Notes: Pulse outputs are counted, then compared
`timescale 1ns/1ns
module cbsl_top_test;
  import cbsl_pkg::*;
  logic clk, rst, gate_bus, gate_panel, abort, veto, panel_rst, rst_sel;
  logic jumper, mem_test, buf_full, buf_ne, cfg, strobe, far_data, far_busy;
  logic data_or, busy_or, gate_win, acq_stop, host_sel;
  logic [7:0] win;
  logic [3:0][3:0] rot;
  logic [13:0] term;
  logic [15:0] addr;
  logic [3:0] st;
  logic [4:0] pv;
  cbsl_wire_t data_line, busy_line;
  cbsl_lamp_t lamps;
  int cnt [5];
  int err_total, n_tests;
  logic [13:0] tv [3] = '{14'h3fff, 14'h0000, 14'h00ff};
  cbsl_top #(.CONV_CYCLES(10)) dut (
    .CLK(clk), .RST(rst), .GATE_BUS(gate_bus), .GATE_PANEL(gate_panel),
    .FAST_ABORT_IN(abort), .VETO(veto), .PANEL_RESET(panel_rst),
    .RESET_TYPE_SELECT(rst_sel), .FAST_ABORT_WINDOW(win),
    .BUSY_SCOPE_JUMPER(jumper), .ROTARY_SEL(rot), .TERM_ON(term),
    .MEM_TEST(mem_test), .EVENT_BUFFER_FULL(buf_full),
    .EVENT_BUFFER_NONEMPTY(buf_ne), .CONFIGURING(cfg),
    .HOST_STROBE(strobe), .HOST_ADDR(addr), .DATA_PRESENT_OR_LINE_I(data_or),
    .BUSY_OR_LINE_I(busy_or), .DATA_PRESENT_LINE(data_line),
    .BUSY_LINE(busy_line), .GATE_WINDOW(gate_win), .CONVERT_START(pv[0]),
    .INTEGRATOR_CLEAR(pv[1]), .CONVERT_ABORT(pv[2]), .BUFFER_RESET(pv[3]),
    .REG_DEFAULTS(pv[4]), .ACQ_STOP(acq_stop), .HOST_SELECT(host_sel),
    .STATUS(st), .LAMPS(lamps)
  );
  cbsl_peer u_peer (
    .clk(clk), .data_line(data_line), .busy_line(busy_line),
    .far_data(far_data), .far_busy(far_busy), .gate(gate_bus),
    .abort(abort), .data_or(data_or), .busy_or(busy_or)
  );
  always @(posedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (pv[i] === 1'b1) cnt[i] = cnt[i] + 1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic access(input logic [15:0] a, input logic hit);
    @(negedge clk);
    strobe = 1'b1;
    addr = a;
    @(negedge clk);
    strobe = 1'b0;
    cmp(16'(host_sel), 16'(hit));
    cmp(16'(lamps.bus_ack_green), 16'(hit));
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    {gate_panel, veto, panel_rst, rst_sel, jumper, mem_test, buf_full} = '0;
    {buf_ne, cfg, strobe, far_data, far_busy, term, addr} = '0;
    win = 8'h20;
    rot = 16'h1234;
    idle(20);
    rst = 1'b0;
    idle(3);
    access(16'h1234, 1'b1);
    access(16'h1235, 1'b0);
    cnt = '{default: 0};
    u_peer.pulse_gate(5);
    cmp(16'(st[STAT_BUSY]), 16'h0001);
    u_peer.pulse_gate(2);
    idle(30);
    cmp(16'(cnt[0]), 16'h0001);
    cmp(16'(st[STAT_BUSY]), 16'h0000);
    veto = 1'b1;
    gate_panel = 1'b1;
    idle(5);
    cmp(16'(gate_win), 16'h0001);
    gate_panel = 1'b0;
    idle(30);
    veto = 1'b0;
    cmp(16'(cnt[0]), 16'h0001);
    cmp(16'(cnt[1]), 16'h0001);
    for (int k = 0; k < 2; k++) begin
      win = k ? 8'h02 : 8'h20;
      cnt = '{default: 0};
      fork
        u_peer.pulse_gate(20);
        u_peer.fast_abort(k ? 15 : 5);
      join
      idle(20);
      cmp(16'(cnt[2]), 16'(1 - k));
      cmp(16'(cnt[0]), 16'(k));
    end
    for (int k = 0; k < 2; k++) begin
      rst_sel = k[0];
      cnt = '{default: 0};
      panel_rst = 1'b1;
      idle(4);
      panel_rst = 1'b0;
      idle(15);
      cmp(16'(cnt[1] + cnt[2] + cnt[3]), 16'h0003);
      cmp(16'(cnt[4]), 16'(k));
    end
    {buf_ne, buf_full} = 2'h3;
    idle(6);
    cmp(16'(st), 16'h000f);
    cmp(16'({lamps.data_yellow, lamps.busy_red}), 16'h0003);
    {buf_ne, buf_full, mem_test} = 3'h1;
    idle(6);
    cmp(16'(st), 16'h000c);
    cmp(16'({data_line, busy_line}), 16'h008d);
    u_peer.pulse_gate(3);
    idle(20);
    cmp(16'(cnt[0]), 16'h0000);
    {mem_test, jumper, far_busy, far_data} = 4'h7;
    idle(6);
    cmp(16'(acq_stop), 16'h0001);
    cmp(16'(st), 16'h000a);
    jumper = 1'b0;
    idle(6);
    cmp(16'(acq_stop), 16'h0000);
    {far_busy, far_data} = 2'h0;
    for (int k = 0; k < 3; k++) begin
      term = tv[k];
      idle(4);
      cmp(16'({lamps.term_green, lamps.term_red}), 16'(2 >> k));
    end
    cfg = 1'b1;
    idle(4);
    cmp(16'({lamps.term_orange, lamps.busy_red, lamps.data_yellow}),
        16'h0007);
    cfg = 1'b0;
    conclude();
  end
endmodule // cbsl_top_test
